// ---- timer_ctrl_pkg.sv ----
package timer_ctrl_pkg;
  localparam int NUM_CH = 6;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [7:0] OFS_OVF_TOGGLE = 8'h07;
  localparam logic [7:0] OFS_CMP_ACT_HI = 8'h08;
  localparam logic [7:0] OFS_CMP_ACT_LO = 8'h09;
  localparam logic [7:0] OFS_CAP_EDGE_HI = 8'h0a;
  localparam logic [7:0] OFS_CAP_EDGE_LO = 8'h0b;
  localparam logic [7:0] OFS_CH_IRQ_EN = 8'h0c;
  localparam logic [7:0] OFS_SYS_CTRL2 = 8'h0d;
  localparam logic [7:0] OFS_CH_FLAG = 8'h0e;
  localparam logic [7:0] OFS_OVF_FLAG = 8'h0f;
  localparam logic [7:0] OFS_CC_SELECT = 8'h10;
  localparam logic [7:0] OFS_PIN_DISC = 8'h11;
  localparam logic [7:0] OFS_PREC_PRESCALE = 8'h12;
  localparam logic [7:0] OFS_PREC_SELECT = 8'h13;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h15;
  // Field positions
  localparam int OVF_IRQ_EN_POS = 7;
  localparam int PRESCALE_MSB = 2;
  localparam int OVF_FLAG_POS = 7;
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [5:0] CH_MASK = 6'h3f;
  // Interrupt status bits: 0 overflow, 1 any compare, 2 any capture
  localparam int IRQ_W = 3;
  typedef enum logic [1:0] {
    ACT_NONE,
    ACT_TOGGLE,
    ACT_LOW,
    ACT_HIGH
  } cmp_action_t;
endpackage

// ---- prescaler.sv ----
`timescale 1ns/10ps
module prescaler #(
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [CNT_W-1:0] div_minus_one,
  output logic tick
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] div_r;

  // New factor only loads when all stages are zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_r <= '0;
    end else if (cnt_r == '0) begin
      div_r <= div_minus_one;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (cnt_r >= div_r) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign tick = (cnt_r >= div_r);

  chk_load_sync: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(div_r) |-> $past(cnt_r) == '0)
    else $error("prescale factor loaded mid count");
endmodule

// ---- timer_channel_control.sv ----
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
// Operation
// - With toggle-on-overflow set in compare mode, overflow inverts the pin.
// - Overflow toggle outranks a forced compare on the same channel.
// - Unimplemented channel bits ignore writes and read zero.
// - Compare action 00 none, 01 toggle, 10 low, 11 high.
// - Nonzero mode or level makes the pin a compare output.
// - Compare output drives the pin only while disconnect is clear.
// - Edge select 00 off, 01 rising, 10 falling, 11 both.
// - Channel interrupt enables gate same-position channel flags.
// - Overflow interrupt enable gates the overflow flag request.
// - Legacy prescale field divides bus clock by two to the field.
// - New prescale takes effect when prescale stages are all zero.
// - Precision select chooses eight-bit prescaler over the legacy field.
// - Overflow occurs when the 16-bit counter wraps from max to zero.
// - Select bit one means output compare, zero means input capture.
module timer_channel_control
#(
  parameter int CHANNELS = timer_ctrl_pkg::NUM_CH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [timer_ctrl_pkg::ADDR_W-1:0] addr,
  input wire logic [timer_ctrl_pkg::DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [timer_ctrl_pkg::DATA_W-1:0] rdata,
  input wire logic [15:0] counter,
  input wire logic [5:0] compare_match,
  input wire logic [5:0] force_compare,
  input wire logic [5:0] pin_in,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe,
  output logic [5:0] capture_event,
  output logic timer_tick,
  output logic overflow_event,
  output logic irq
);
  import timer_ctrl_pkg::*;

  logic [5:0] ovf_tog_r, cc_sel_r, pin_disc_r, ch_ie_r, ch_flag_r;
  logic [7:0] cmp_hi_r, cmp_lo_r, edge_hi_r, edge_lo_r, sys2_r, prec_r;
  logic prec_sel_r, prec_locked_r, ovf_flag_r;
  logic [IRQ_W-1:0] irq_stat_r, irq_mask_r;
  logic [5:0] compare_output_r, pin_s1_r, pin_s2_r, pin_d_r;
  logic [15:0] cnt_d_r;
  logic [7:0] rdata_r;
  logic [7:0] pre_div;
  logic [5:0] cmp_mode_bit, cmp_level_bit, edge_sel_hi, edge_sel_lo;
  logic [5:0] cap_ev;
  logic [2:0] sync_fill_r;
  logic [IRQ_W-1:0] irq_ev;
  logic ovf_irq;

  function automatic logic wr_to(input logic [7:0] ofs);
    return wr_stb && addr == ofs;
  endfunction

  // Two-bit pair of channel ch from a hi/lo register couple
  function automatic logic [1:0] pair_of(input logic [7:0] hi,
                                         input logic [7:0] lo,
                                         input int ch);
    logic [15:0] both;
    both = {hi, lo};
    return both[2*ch +: 2];
  endfunction

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      {cmp_mode_bit[i], cmp_level_bit[i]} = pair_of(cmp_hi_r, cmp_lo_r, i);
      {edge_sel_hi[i], edge_sel_lo[i]} = pair_of(edge_hi_r, edge_lo_r, i);
    end
  end

  // Register writes; only channel bits kept
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ovf_tog_r <= '0;
      cc_sel_r <= '0;
      pin_disc_r <= '0;
      ch_ie_r <= '0;
    end else begin
      if (wr_to(OFS_OVF_TOGGLE)) ovf_tog_r <= wdata[5:0];
      if (wr_to(OFS_CC_SELECT)) cc_sel_r <= wdata[5:0];
      if (wr_to(OFS_PIN_DISC)) pin_disc_r <= wdata[5:0];
      if (wr_to(OFS_CH_IRQ_EN)) ch_ie_r <= wdata[5:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmp_hi_r <= RST_REG;
      cmp_lo_r <= RST_REG;
      edge_hi_r <= RST_REG;
      edge_lo_r <= RST_REG;
    end else begin
      // Upper registers hold channels 4 and 5 only
      if (wr_to(OFS_CMP_ACT_HI)) cmp_hi_r <= {4'h0, wdata[3:0]};
      if (wr_to(OFS_CMP_ACT_LO)) cmp_lo_r <= wdata;
      if (wr_to(OFS_CAP_EDGE_HI)) edge_hi_r <= {4'h0, wdata[3:0]};
      if (wr_to(OFS_CAP_EDGE_LO)) edge_lo_r <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sys2_r <= RST_REG;
      prec_r <= RST_REG;
      prec_sel_r <= 1'b0;
      prec_locked_r <= 1'b0;
    end else begin
      if (wr_to(OFS_SYS_CTRL2)) begin
        sys2_r <= {wdata[OVF_IRQ_EN_POS], 4'h0, wdata[PRESCALE_MSB:0]};
      end
      if (wr_to(OFS_PREC_PRESCALE)) prec_r <= wdata;
      // Precision select is write-once after reset
      if (wr_to(OFS_PREC_SELECT) && !prec_locked_r) begin
        prec_sel_r <= wdata[0];
        prec_locked_r <= 1'b1;
      end
    end
  end

  // Divider minus one: legacy 2^n - 1, or precision value
  always_comb begin
    if (prec_sel_r) begin
      pre_div = prec_r;
    end else begin
      pre_div = 8'((9'h001 << sys2_r[PRESCALE_MSB:0]) - 9'h001);
    end
  end

  prescaler #(.CNT_W(8)) u_pre (
    .clk(clk),
    .rst_n(rst_n),
    .div_minus_one(pre_div),
    .tick(timer_tick)
  );

  // Overflow seen as counter wrap
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_d_r <= 16'h0000;
    end else begin
      cnt_d_r <= counter;
    end
  end
  assign overflow_event = cnt_d_r == CNT_MAX && counter == 16'h0000;

  // Output compare pin state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      compare_output_r <= '0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (cc_sel_r[i]) begin
          if (ovf_tog_r[i] && overflow_event) begin
            compare_output_r[i] <= ~compare_output_r[i];
          end else if (compare_match[i] || force_compare[i]) begin
            unique case (cmp_action_t'({cmp_mode_bit[i], cmp_level_bit[i]}))
              ACT_NONE: compare_output_r[i] <= compare_output_r[i];
              ACT_TOGGLE: compare_output_r[i] <= ~compare_output_r[i];
              ACT_LOW: compare_output_r[i] <= 1'b0;
              ACT_HIGH: compare_output_r[i] <= 1'b1;
            endcase
          end
        end
      end
    end
  end

  assign pin_out = compare_output_r;
  assign pin_oe = cc_sel_r & (cmp_mode_bit | cmp_level_bit)
                  & ~pin_disc_r;

  // Input pins synchronised before edge detection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_d_r <= '0;
      sync_fill_r <= '0;
    end else begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
      sync_fill_r <= {sync_fill_r[1:0], 1'b1};
    end
  end

  // No edges until the pipe holds real levels: a high pin faked a rise
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      cap_ev[i] = sync_fill_r[2] && !cc_sel_r[i] &&
        ((edge_sel_lo[i] && pin_s2_r[i] && !pin_d_r[i]) ||
         (edge_sel_hi[i] && !pin_s2_r[i] && pin_d_r[i]));
    end
  end
  assign capture_event = cap_ev;

  // Channel and overflow flags; set wins over write-one clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ch_flag_r <= '0;
      ovf_flag_r <= 1'b0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (cap_ev[i] || (cc_sel_r[i] && compare_match[i] &&
            !force_compare[i])) begin
          ch_flag_r[i] <= 1'b1;
        end else if (wr_to(OFS_CH_FLAG) && wdata[i]) begin
          ch_flag_r[i] <= 1'b0;
        end
      end
      if (overflow_event) begin
        ovf_flag_r <= 1'b1;
      end else if (wr_to(OFS_OVF_FLAG) && wdata[OVF_FLAG_POS]) begin
        ovf_flag_r <= 1'b0;
      end
    end
  end

  assign ovf_irq = ovf_flag_r && sys2_r[OVF_IRQ_EN_POS];
  assign irq_ev = {|(ch_flag_r & ch_ie_r & ~cc_sel_r),
                   |(ch_flag_r & ch_ie_r & cc_sel_r), ovf_irq};

  // Sticky status: overflow, compare, capture
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else begin
      for (int b = 0; b < IRQ_W; b++) begin
        if (irq_ev[b]) irq_stat_r[b] <= 1'b1;
        else if (wr_to(OFS_IRQ_STATUS) && wdata[b]) irq_stat_r[b] <= 1'b0;
      end
      if (wr_to(OFS_IRQ_MASK)) irq_mask_r <= wdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // Read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_r <= RST_REG;
    end else if (rd_stb) begin
      unique case (addr)
        OFS_OVF_TOGGLE: rdata_r <= {2'b00, ovf_tog_r};
        OFS_CMP_ACT_HI: rdata_r <= cmp_hi_r;
        OFS_CMP_ACT_LO: rdata_r <= cmp_lo_r;
        OFS_CAP_EDGE_HI: rdata_r <= edge_hi_r;
        OFS_CAP_EDGE_LO: rdata_r <= edge_lo_r;
        OFS_CH_IRQ_EN: rdata_r <= {2'b00, ch_ie_r};
        OFS_SYS_CTRL2: rdata_r <= sys2_r;
        OFS_CH_FLAG: rdata_r <= {2'b00, ch_flag_r};
        OFS_OVF_FLAG: rdata_r <= {ovf_flag_r, 7'h00};
        OFS_CC_SELECT: rdata_r <= {2'b00, cc_sel_r};
        OFS_PIN_DISC: rdata_r <= {2'b00, pin_disc_r};
        OFS_PREC_PRESCALE: rdata_r <= prec_r;
        OFS_PREC_SELECT: rdata_r <= {7'h00, prec_sel_r};
        OFS_IRQ_STATUS: rdata_r <= {5'h00, irq_stat_r};
        OFS_IRQ_MASK: rdata_r <= {5'h00, irq_mask_r};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end
  assign rdata = rdata_r;

  chk_ovf_toggle: assert property (@(posedge clk) disable iff (!rst_n)
    overflow_event && ovf_tog_r[0] && cc_sel_r[0] |=>
      pin_out[0] != $past(pin_out[0]))
    else $error("overflow toggle missed on channel 0");
  chk_toggle_priority: assert property (@(posedge clk)
    disable iff (!rst_n)
    overflow_event && ovf_tog_r[0] && cc_sel_r[0] && force_compare[0] |=>
      pin_out[0] != $past(pin_out[0]))
    else $error("force beat overflow toggle");
  chk_unimpl_zero: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rd_stb) && $past(addr) == OFS_OVF_TOGGLE |->
      rdata[7:6] == 2'b00)
    else $error("unimplemented bits read nonzero");
  chk_action_high: assert property (@(posedge clk) disable iff (!rst_n)
    cc_sel_r[0] && compare_match[0] && !(ovf_tog_r[0] && overflow_event) &&
      cmp_mode_bit[0] && cmp_level_bit[0] |=> pin_out[0])
    else $error("set action failed");
  chk_pin_enable: assert property (@(posedge clk) disable iff (!rst_n)
    pin_disc_r[0] |-> !pin_oe[0])
    else $error("disconnected pin driven");
  chk_pin_output: assert property (@(posedge clk) disable iff (!rst_n)
    cc_sel_r[0] && !pin_disc_r[0] && (cmp_mode_bit[0] || cmp_level_bit[0])
      |-> pin_oe[0])
    else $error("compare pin not enabled");
  chk_edge_off: assert property (@(posedge clk) disable iff (!rst_n)
    !edge_sel_hi[1] && !edge_sel_lo[1] |-> !capture_event[1])
    else $error("capture while disabled");
  chk_ovf_irq: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(ovf_flag_r) && sys2_r[7] && irq_mask_r[0] |=> irq)
    else $error("overflow irq missing");
  cov_ovf_toggle: cover property (@(posedge clk)
    overflow_event && |(ovf_tog_r & cc_sel_r));
  cov_capture: cover property (@(posedge clk) |capture_event);
  cov_irq: cover property (@(posedge clk) $rose(irq));
endmodule

// ---- pin_model.sv ----
`timescale 1ns/10ps
// Channel pins: a pin the block drives carries its level, others the
// level that the outside source is told to hold
module pin_model (
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  input wire logic [5:0] ext_lvl,
  output logic [5:0] pin_in
);
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_lvl[i];
    end
  end
endmodule

// ---- test_timer_channel_control.sv ----
`timescale 1ns/10ps
module test_timer_channel_control;
  import timer_ctrl_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 0;
  logic rd_stb = 0;
  logic [7:0] rdata;
  logic [15:0] counter = 16'h0100;
  logic [5:0] compare_match = 6'h00;
  logic [5:0] force_compare = 6'h00;
  logic [5:0] ext_lvl = 6'h00;
  logic [5:0] pin_in, pin_out, pin_oe, capture_event;
  logic timer_tick, overflow_event, irq;
  int n_mismatch = 0;
  int check_count = 0;
  int caps = 0;
  int n;
  timer_channel_control timer_channel_control_i (.clk(clk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .counter(counter), .compare_match(compare_match),
    .force_compare(force_compare), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .capture_event(capture_event),
    .timer_tick(timer_tick), .overflow_event(overflow_event), .irq(irq));
  pin_model pin_model_i (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_lvl(ext_lvl), .pin_in(pin_in));
  always #20 clk = ~clk;
  always @(negedge clk) if (capture_event[1] === 1'b1) caps++;
  task close_out;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1;
    @(posedge clk);
    wr_stb <= 0;
  endtask
  task rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1;
    @(posedge clk);
    rd_stb <= 0;
    @(negedge clk);
    chk(rdata, e);
  endtask
  task match(input logic [5:0] m);
    @(posedge clk);
    compare_match <= m;
    @(posedge clk);
    compare_match <= 0;
    repeat (3) @(negedge clk);
  endtask
  // Wrap the counter; force lands in the overflow cycle itself
  task ovf(input logic [5:0] f);
    @(posedge clk);
    counter <= 16'hffff;
    @(posedge clk);
    counter <= 16'h0000;
    force_compare <= f;
    @(negedge clk);
    chk({7'h0, overflow_event}, 8'h01);
    @(posedge clk);
    counter <= 16'h0001;
    force_compare <= 0;
    repeat (3) @(negedge clk);
  endtask
  // Cycles between two ticks, after syncing to a first one
  task per(output int p);
    int k;
    k = 0;
    do begin @(negedge clk); k++; end while (timer_tick !== 1'b1 && k < 400);
    p = 0;
    do begin @(negedge clk); p++; end while (timer_tick !== 1'b1 && p < 400);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1;
    for (int a = 7; a <= 13; a++) rc(a[7:0], 8'h00);
    rc(8'h00, 8'h00);
    wr(8'h07, 8'hff);
    rc(8'h07, 8'h3f);
    wr(8'h07, 8'h00);
    wr(8'h08, 8'hff);
    rc(8'h08, 8'h0f);
    wr(8'h10, 8'h11);
    match(6'h30);
    chk({7'h0, pin_out[4]}, 8'h01);
    chk({7'h0, pin_oe[4]}, 8'h01);
    chk({7'h0, pin_out[5]}, 8'h00);
    rc(8'h0e, 8'h10);
    $display("registers done");
    // Codes 3,2,1,0 give high, low, toggle back high, then no change
    for (int c = 3; c >= 0; c--) begin
      wr(8'h09, c[7:0]);
      match(6'h01);
      chk({7'h0, pin_oe[0]}, {7'h0, c != 0});
      chk({7'h0, pin_out[0]}, {7'h0, c != 2});
    end
    wr(8'h09, 8'h01);
    wr(8'h11, 8'h01);
    repeat (2) @(negedge clk);
    chk({7'h0, pin_oe[0]}, 8'h00);
    wr(8'h11, 8'h00);
    $display("compare done");
    wr(8'h09, 8'h03);
    ovf(6'h00);
    chk({7'h0, pin_out[0]}, 8'h01);
    wr(8'h07, 8'h01);
    ovf(6'h01);
    chk({7'h0, pin_out[0]}, 8'h00);
    ovf(6'h00);
    chk({7'h0, pin_out[0]}, 8'h01);
    wr(8'h07, 8'h00);
    $display("overflow toggle done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h0b, 8'(c << 2));
      caps = 0;
      @(posedge clk) ext_lvl[1] <= 1;
      repeat (6) @(posedge clk);
      ext_lvl[1] <= 0;
      repeat (6) @(posedge clk);
      chk(8'(caps), 8'(c[0]) + 8'(c[1]));
    end
    $display("capture done");
    wr(8'h15, 8'h07);
    match(6'h01);
    ovf(6'h00);
    chk({7'h0, irq}, 8'h00);
    wr(8'h0e, 8'h3f);
    wr(8'h0f, 8'h80);
    wr(8'h14, 8'h07);
    wr(8'h0c, 8'h01);
    match(6'h01);
    chk({7'h0, irq}, 8'h01);
    wr(8'h15, 8'h00);
    repeat (2) @(negedge clk);
    chk({7'h0, irq}, 8'h00);
    wr(8'h15, 8'h07);
    wr(8'h0e, 8'h3f);
    wr(8'h14, 8'h07);
    repeat (2) @(negedge clk);
    chk({7'h0, irq}, 8'h00);
    wr(8'h0d, 8'h80);
    ovf(6'h00);
    chk({7'h0, irq}, 8'h01);
    wr(8'h0f, 8'h80);
    wr(8'h14, 8'h07);
    repeat (2) @(negedge clk);
    chk({7'h0, irq}, 8'h00);
    $display("interrupt done");
    for (int p = 0; p < 8; p++) begin
      wr(8'h0d, p[7:0]);
      per(n);
      per(n);
      chk(8'(n), 8'(1 << p));
    end
    // Old divide by 128 must run out before the new one applies
    per(n);
    wr(8'h0d, 8'h00);
    n = 0;
    do begin @(negedge clk); n++; end while (timer_tick !== 1'b1 && n < 400);
    chk({7'h0, n > 100}, 8'h01);
    wr(8'h12, 8'h04);
    wr(8'h13, 8'h01);
    per(n);
    per(n);
    chk(8'(n), 8'h05);
    wr(8'h13, 8'h00);
    per(n);
    per(n);
    chk(8'(n), 8'h05);
    $display("prescaler done");
    close_out();
  end
endmodule
